/* File: uwc_pkg.sv */
// Constants and types shared by the serial wire-mode and clock control block
package uwc_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] UWC_OFF_CTRL = 8'h00;
    localparam logic [7:0] UWC_OFF_STAT = 8'h04;
    localparam logic [7:0] UWC_OFF_DATA = 8'h08;
    localparam logic [7:0] UWC_OFF_PORT = 8'h0C;
    localparam logic [7:0] UWC_OFF_DIR = 8'h10;
    localparam logic [7:0] UWC_OFF_PIN = 8'h14;
    // Control register fields
    localparam int UWC_WM_LSB = 4;
    localparam int UWC_CS_LSB = 2;
    localparam int UWC_CLK_BIT = 1;
    localparam int UWC_TC_BIT = 0;
    // Status register fields
    localparam int UWC_SIF_BIT = 7;
    localparam int UWC_OIF_BIT = 6;
    localparam int UWC_CNT_LSB = 0;
    // Pin indices within the three-pin port
    localparam int UWC_PIN_DO = 0;
    localparam int UWC_PIN_DI = 1;
    localparam int UWC_PIN_CK = 2;
    // Values after reset
    localparam logic [1:0] UWC_WM_RST = 2'h0;
    localparam logic [1:0] UWC_CS_RST = 2'h0;
    localparam logic [7:0] UWC_SHIFT_RST = 8'h00;
    localparam logic [3:0] UWC_CNT_RST = 4'h0;
    localparam logic [3:0] UWC_CNT_MAX = 4'hF;
    localparam logic [2:0] UWC_PORT_RST = 3'h0;
    // Released pin level, so the edge detectors see no edge after reset
    localparam logic [2:0] UWC_PIN_IDLE = 3'h7;
    localparam logic [31:0] UWC_RDATA_RST = 32'h0000_0000;
    // Wire modes
    typedef enum logic [1:0] {
        UWC_WM_OFF = 2'h0,
        UWC_WM_THREE = 2'h1,
        UWC_WM_TWO = 2'h2,
        UWC_WM_TWO_HOLD = 2'h3
    } uwc_wire_mode_t;
endpackage

/* File: uwc_ctrl.sv */
// Wire-mode pin control, clock source selection and Avalon-MM registers
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Mode zero: serial outputs, hold, detector off.
// - Three-wire: shift output replaces port bit.
// - Three-wire: input and clock pins plain.
// - Two-wire: open-collector drivers gated by direction.
// - Data line low on shift or port zero.
// - Clock line low on port zero or hold.
// - Start condition holds clock until flag cleared.
// - Two-wire: data and clock line pull-ups off, inputs untouched.
// - Mode three: overflow also holds clock line.
// - Inputs work the same in every mode.
// - External clock: output on opposite edge.
// - Source zero: strobe bit is software clock.
// - Clock selection table for register and counter.
// - External source: strobe bit selects toggle counting.
// - Strobe shifts once, counts once, immediate output.
// - Toggle bit inverts clock pin port value.
// - Strobe bit reads as zero.
// - Toggle bit reads as zero.
// - Overflow flag set on wrap to zero.
// - Start flag cleared only by writing one.
module uwc_ctrl
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic timer_match,
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe,
    output logic [2:0] pin_pullup
);
    import uwc_pkg::*;

    logic [2:0] pin_s1_reg, pin_s1_next;
    logic [2:0] pin_s2_reg, pin_s2_next;
    logic [2:0] pin_d_reg, pin_d_next;
    uwc_wire_mode_t wm_reg, wm_next;
    logic [1:0] cs_reg, cs_next;
    logic clk_sel_reg, clk_sel_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] cnt_reg, cnt_next;
    logic sif_reg, sif_next;
    logic oif_reg, oif_next;
    logic [2:0] port_reg, port_next;
    logic [2:0] dir_reg, dir_next;
    logic latch_reg, latch_next;
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [2:0] out_reg, out_next;
    logic [2:0] oe_reg, oe_next;
    logic [2:0] pu_reg, pu_next;
    logic ck_rise, ck_fall, di_fall, ext_src, two_wire;
    logic shift_clk, cnt_clk, latch_upd, start_ev, hold;
    logic wr, wr_ctrl, wr_stat, strobe_w, toggle_w;

    // Synchroniser next values and pin edge detection
    always_comb
    begin
        // Two-flop synchronisers; edges seen on the second stage only
        pin_s1_next = pin_in;
        pin_s2_next = pin_s1_reg;
        pin_d_next = pin_s2_reg;
        ck_rise = pin_s2_reg[UWC_PIN_CK] & ~pin_d_reg[UWC_PIN_CK];
        ck_fall = ~pin_s2_reg[UWC_PIN_CK] & pin_d_reg[UWC_PIN_CK];
        di_fall = ~pin_s2_reg[UWC_PIN_DI] & pin_d_reg[UWC_PIN_DI];

    end

    // Bus access completes at the edge where waitrequest is low
    always_comb
    begin
        wr = avs_write & ~wait_reg & avs_byteenable[0];
        wr_ctrl = wr && (avs_address == UWC_OFF_CTRL);
        wr_stat = wr && (avs_address == UWC_OFF_STAT);
        strobe_w = wr_ctrl & avs_writedata[UWC_CLK_BIT];
        toggle_w = wr_ctrl & avs_writedata[UWC_TC_BIT];

        ext_src = cs_reg[1];
        two_wire = wm_reg[1];

        // Shift register clock selection
        if (ext_src)
        begin
            shift_clk = cs_reg[0] ? ck_fall : ck_rise;
        end
        else if (cs_reg[0])
        begin
            shift_clk = timer_match;
        end
        else
        begin
            shift_clk = strobe_w;
        end

        // Counter clock: external source counts both edges unless toggle strobe selected, otherwise follows the shift clock
        if (ext_src)
        begin
            cnt_clk = clk_sel_reg ? toggle_w : (ck_rise | ck_fall);
        end
        else
        begin
            cnt_clk = shift_clk;
        end

    end

    // Shifted-in bit is the one sampled a cycle earlier; a write wins
    always_comb
    begin
        shift_next = shift_reg;
        if (shift_clk)
        begin
            shift_next = {shift_reg[6:0], pin_d_reg[UWC_PIN_DI]};
        end
        if (wr && (avs_address == UWC_OFF_DATA))
        begin
            shift_next = avs_writedata[7:0];
        end

    end

    // Counter and overflow flag; a set beats a clear in the same cycle
    always_comb
    begin
        cnt_next = cnt_reg;
        oif_next = oif_reg;
        if (wr_stat)
        begin
            cnt_next = avs_writedata[UWC_CNT_LSB +: 4];
            if (avs_writedata[UWC_OIF_BIT])
            begin
                oif_next = 1'b0;
            end
        end
        else if (cnt_clk)
        begin
            cnt_next = cnt_reg + 4'h1;
        end
        if (cnt_clk && (cnt_reg == UWC_CNT_MAX))
        begin
            oif_next = 1'b1;
        end

    end

    // Start detector: idle when disabled, any clock edge in three-wire
    always_comb
    begin
        unique case (wm_reg)
            UWC_WM_OFF: start_ev = 1'b0;
            UWC_WM_THREE: start_ev = ck_rise | ck_fall;
            default: start_ev = di_fall & pin_s2_reg[UWC_PIN_CK] & pin_d_reg[UWC_PIN_CK];
        endcase
        sif_next = sif_reg;
        if (wr_stat && avs_writedata[UWC_SIF_BIT])
        begin
            sif_next = 1'b0;
        end
        if (start_ev)
        begin
            sif_next = 1'b1;
        end

    end

    // Output latch: opposite edge for external clocks, else transparent
    always_comb
    begin
        latch_upd = cs_reg[0] ? ck_rise : ck_fall;
        if (!ext_src || latch_upd)
        begin
            latch_next = shift_next[7];
        end
        else
        begin
            latch_next = latch_reg;
        end

    end

    // Control register; toggle acts only as a write pulse, strobe bit also kept as counter clock select
    always_comb
    begin
        wm_next = wm_reg;
        cs_next = cs_reg;
        clk_sel_next = clk_sel_reg;
        if (wr_ctrl)
        begin
            wm_next = uwc_wire_mode_t'(avs_writedata[UWC_WM_LSB +: 2]);
            cs_next = avs_writedata[UWC_CS_LSB +: 2];
            clk_sel_next = avs_writedata[UWC_CLK_BIT];
        end

    end

    // Port registers; toggle inverts clock bit whatever its direction
    always_comb
    begin
        port_next = port_reg;
        dir_next = dir_reg;
        if (wr && (avs_address == UWC_OFF_PORT))
        begin
            port_next = avs_writedata[2:0];
        end
        if (wr && (avs_address == UWC_OFF_DIR))
        begin
            dir_next = avs_writedata[2:0];
        end
        if (toggle_w)
        begin
            port_next[UWC_PIN_CK] = ~port_next[UWC_PIN_CK];
        end

    end

    // Clock hold from start condition, and from overflow in mode three
    always_comb
    begin
        hold = (two_wire & sif_next) |
               ((wm_reg == UWC_WM_TWO_HOLD) & oif_next);

        // Pin drivers default to plain port behaviour
        out_next = port_next;
        oe_next = dir_next;
        pu_next = ~dir_next & port_next;
        unique case (wm_reg)
            UWC_WM_OFF:
            begin
                out_next = port_next;
            end
            UWC_WM_THREE:
            begin
                out_next[UWC_PIN_DO] = latch_next;
            end
            default:
            begin
                // Open collector: drive only low, enable follows direction
                out_next[UWC_PIN_DI] = 1'b0;
                out_next[UWC_PIN_CK] = 1'b0;
                oe_next[UWC_PIN_DI] = dir_next[UWC_PIN_DI] &
                    (~latch_next | ~port_next[UWC_PIN_DI]);
                oe_next[UWC_PIN_CK] = dir_next[UWC_PIN_CK] &
                    (~port_next[UWC_PIN_CK] | hold);
                pu_next[UWC_PIN_DI] = 1'b0;
                pu_next[UWC_PIN_CK] = 1'b0;
            end
        endcase

    end

    // Read data is captured at the same edge where waitrequest drops
    always_comb
    begin
        wait_next = ~((avs_read | avs_write) & wait_reg);
        rdata_next = rdata_reg;
        if (avs_read && wait_reg)
        begin
            rdata_next = UWC_RDATA_RST;
            unique case (avs_address)
                UWC_OFF_CTRL:
                begin
                    // Strobe and toggle bits stay zero here
                    rdata_next[UWC_WM_LSB +: 2] = wm_reg;
                    rdata_next[UWC_CS_LSB +: 2] = cs_reg;
                end
                UWC_OFF_STAT:
                begin
                    rdata_next[UWC_SIF_BIT] = sif_reg;
                    rdata_next[UWC_OIF_BIT] = oif_reg;
                    rdata_next[UWC_CNT_LSB +: 4] = cnt_reg;
                end
                UWC_OFF_DATA: rdata_next[7:0] = shift_reg;
                UWC_OFF_PORT: rdata_next[2:0] = port_reg;
                UWC_OFF_DIR: rdata_next[2:0] = dir_reg;
                UWC_OFF_PIN: rdata_next[2:0] = pin_s2_reg;
                default: rdata_next = UWC_RDATA_RST;
            endcase
        end
    end

    // Pin synchronisers; reset to the released level to avoid a false edge
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pin_s1_reg <= UWC_PIN_IDLE;
            pin_s2_reg <= UWC_PIN_IDLE;
            pin_d_reg <= UWC_PIN_IDLE;
        end
        else if (clk_en)
        begin
            pin_s1_reg <= pin_s1_next;
            pin_s2_reg <= pin_s2_next;
            pin_d_reg <= pin_d_next;
        end
    end

    // Bus handshake registers; clock enable low freezes the bus too
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= UWC_RDATA_RST;
        end
        else if (clk_en)
        begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    // Control and port registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wm_reg <= uwc_wire_mode_t'(UWC_WM_RST);
            cs_reg <= UWC_CS_RST;
            clk_sel_reg <= 1'b0;
            port_reg <= UWC_PORT_RST;
            dir_reg <= UWC_PORT_RST;
        end
        else if (clk_en)
        begin
            wm_reg <= wm_next;
            cs_reg <= cs_next;
            clk_sel_reg <= clk_sel_next;
            port_reg <= port_next;
            dir_reg <= dir_next;
        end
    end

    // Shift register, counter, flags and output latch
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            shift_reg <= UWC_SHIFT_RST;
            cnt_reg <= UWC_CNT_RST;
            sif_reg <= 1'b0;
            oif_reg <= 1'b0;
            latch_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            sif_reg <= sif_next;
            oif_reg <= oif_next;
            latch_reg <= latch_next;
        end
    end

    // Pin drivers; reset leaves every pin undriven and unpulled
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            out_reg <= UWC_PORT_RST;
            oe_reg <= UWC_PORT_RST;
            pu_reg <= UWC_PORT_RST;
        end
        else if (clk_en)
        begin
            out_reg <= out_next;
            oe_reg <= oe_next;
            pu_reg <= pu_next;
        end
    end

    // Outputs straight from flip-flops
    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign pin_out = out_reg;
    assign pin_oe = oe_reg;
    assign pin_pullup = pu_reg;
endmodule

`default_nettype wire

/* File: uwc_ctrl_asserts.sv */
// Port-level checks for the wire-mode and clock control block
`timescale 1ns/1ps
`default_nettype none
module uwc_ctrl_asserts
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] pin_pullup
);
    import uwc_pkg::*;
    // A low clock enable freezes the bus, so the checks pause with it
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst || !clk_en);
    logic rd_done;
    logic mapped;
    // Helpers: a completed read and a decoded address
    assign rd_done = avs_read && !avs_waitrequest;
    assign mapped = avs_address inside {UWC_OFF_CTRL, UWC_OFF_STAT, UWC_OFF_DATA,
        UWC_OFF_PORT, UWC_OFF_DIR, UWC_OFF_PIN};
    sequence acc_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence acc_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    bus_answer_a: assert property (acc_req |=> acc_ack)
        else $error("bus access not answered for exactly one cycle");
    idle_wait_a: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest dropped without a request");
    reset_quiet_a: assert property ($fell(rst) |-> pin_oe == 3'h0 && pin_pullup == 3'h0)
        else $error("pins not quiet after reset");
    strobe_reads_zero_a: assert property (rd_done && avs_address == UWC_OFF_CTRL |-> avs_readdata[1:0] == 2'h0)
        else $error("strobe bits read back nonzero");
    unmapped_zero_a: assert property (rd_done && !mapped |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (rd_done |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("read data above the byte not zero");
    rdata_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    pullup_drive_a: assert property ((pin_pullup & pin_oe) == 3'h0)
        else $error("pull-up on a driven pin");
endmodule
bind uwc_ctrl uwc_ctrl_asserts uwc_ctrl_asserts_inst (.ref_clk(ref_clk), .rst(rst),
    .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup));
`default_nettype wire

/* File: uwc_peer.sv */
// Serial bus peer: pulled-up wired lines and a link clock inside frames
`timescale 1ns/1ps
`default_nettype none
module uwc_peer
(
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic frame,
    output logic [2:0] pin_in
);
    logic scl_low;
    // 48 ns link clock, offset 1 ns so it never meets a ref_clk edge
    initial
    begin
        scl_low = 1'b0;
        #1;
        forever
        begin
            #24;
            scl_low = frame ? !scl_low : 1'b0; // Stands released between frames
        end
    end
    // Wired-AND: any low drive wins, a released line floats high
    assign pin_in = ~((pin_oe & ~pin_out) | {scl_low, 2'h0});
endmodule
`default_nettype wire

/* File: uwc_ctrl_bench.sv */
// Self-checking bench for the wire-mode and clock control block
`timescale 1ns/1ps
`default_nettype none
module uwc_ctrl_bench;
    import uwc_pkg::*;
    logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, timer_match, frame;
    logic [7:0] avs_address;
    logic clk_en;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic [2:0] pin_in, pin_out, pin_oe, pin_pullup;
    int miscompares, checks, cycles;
    uwc_ctrl uwc_ctrl_inst (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer_match(timer_match), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
    uwc_peer uwc_peer_inst (.pin_out(pin_out), .pin_oe(pin_oe), .frame(frame), .pin_in(pin_in));
    // Free-running system clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = !ref_clk;
    end
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Watchdog: the whole run needs well under this many cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            finish_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One bus access; request held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= 32'(d);
        avs_write <= w;
        avs_read <= !w;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 50)
            miscompares++;
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic t_reset();
        rd(UWC_OFF_CTRL, 8'h00);
        rd(UWC_OFF_STAT, 8'h00);
        // A write without its low byte enabled is ignored
        avs_byteenable <= 4'hE;
        wr(UWC_OFF_CTRL, 8'h30);
        avs_byteenable <= 4'hF;
        rd(UWC_OFF_CTRL, 8'h00);
        rd(8'h18, 8'h00);
        chk({5'h00, pin_oe}, 8'h00);
    endtask
    task automatic t_modes();
        wr(UWC_OFF_DIR, 8'h00);
        wr(UWC_OFF_PORT, 8'h07);
        for (int m = 0; m < 4; m++)
        begin
            wr(UWC_OFF_CTRL, 8'(m << UWC_WM_LSB));
            idle(3);
            chk({5'h00, pin_pullup}, (m > 1) ? 8'h01 : 8'h07);
            chk({5'h00, pin_oe}, 8'h00);
        end
    endtask
    // Data low with the clock high is a start: clock held until the flag clears
    task automatic t_open();
        wr(UWC_OFF_CTRL, 8'h20);
        wr(UWC_OFF_PORT, 8'h06);
        wr(UWC_OFF_DATA, 8'h00);
        wr(UWC_OFF_DIR, 8'h06);
        idle(8);
        chk({5'h00, pin_oe}, 8'h06);
        chk({5'h00, pin_out}, 8'h00);
        rd(UWC_OFF_STAT, 8'h80);
        wr(UWC_OFF_STAT, 8'h80);
        idle(3);
        chk({5'h00, pin_oe}, 8'h02);
        wr(UWC_OFF_DATA, 8'h80);
        idle(4);
        chk({5'h00, pin_oe}, 8'h00);
        wr(UWC_OFF_PORT, 8'h02);
        idle(3);
        chk({5'h00, pin_oe}, 8'h04);
        wr(UWC_OFF_CTRL, 8'h00);
        wr(UWC_OFF_DIR, 8'h00);
        wr(UWC_OFF_PORT, 8'h00);
    endtask
    task automatic t_timer();
        wr(UWC_OFF_CTRL, 8'h04);
        repeat (3)
        begin
            timer_match <= 1'b1;
            @(posedge ref_clk);
            timer_match <= 1'b0;
            idle(2);
        end
        rd(UWC_OFF_STAT, 8'h03);
        // A match while the clock enable is low must not count
        clk_en <= 1'b0;
        timer_match <= 1'b1;
        @(posedge ref_clk);
        timer_match <= 1'b0;
        clk_en <= 1'b1;
        rd(UWC_OFF_STAT, 8'h03);
    endtask
    // External clock with outputs off; then the toggle strobe clocks the counter
    task automatic t_ext();
        wr(UWC_OFF_CTRL, 8'h08);
        wr(UWC_OFF_STAT, 8'h00);
        for (int s = 0; s < 2; s++)
        begin
            frame <= 1'b1;
            idle(48);
            frame <= 1'b0;
            idle(10);
            rd(UWC_OFF_STAT, 8'h08);
            wr(UWC_OFF_CTRL, 8'h0A);
        end
        wr(UWC_OFF_CTRL, 8'h0B);
        rd(UWC_OFF_PORT, 8'h04);
        wr(UWC_OFF_CTRL, 8'h0B);
        rd(UWC_OFF_STAT, 8'h0A);
    endtask
    task automatic t_ovf();
        wr(UWC_OFF_PORT, 8'h04);
        wr(UWC_OFF_DIR, 8'h04);
        wr(UWC_OFF_CTRL, 8'h30);
        wr(UWC_OFF_STAT, 8'hCE);
        wr(UWC_OFF_DATA, 8'h81);
        wr(UWC_OFF_CTRL, 8'h32);
        rd(UWC_OFF_DATA, 8'h03);
        rd(UWC_OFF_STAT, 8'h0F);
        rd(UWC_OFF_CTRL, 8'h30);
        wr(UWC_OFF_CTRL, 8'h32);
        idle(3);
        rd(UWC_OFF_STAT, 8'h40);
        chk({5'h00, pin_oe}, 8'h04);
        wr(UWC_OFF_STAT, 8'h40);
        idle(3);
        chk({5'h00, pin_oe}, 8'h00);
    endtask
    // Main sequence
    initial
    begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0000_0000;
        timer_match = 1'b0;
        frame = 1'b0;
        clk_en = 1'b1;
        avs_byteenable = 4'hF;
        idle(3);
        rst <= 1'b0;
        idle(1);
        t_reset();
        t_modes();
        t_open();
        t_timer();
        t_ext();
        t_ovf();
        finish_test();
    end
endmodule
`default_nettype wire
